/* wdc_pkg.sv */
// package for the watchdog control and reset flag register block
package wdc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] WDC_ADDR = 8'hd8;
    localparam logic [7:0] WDC_TA_KEY1 = 8'haa;
    localparam logic [7:0] WDC_TA_KEY2 = 8'h55;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WDC_BIT_BAUD = 7;
    localparam int WDC_BIT_POR = 6;
    localparam int WDC_BIT_PFIE = 5;
    localparam int WDC_BIT_PFF = 4;
    localparam int WDC_BIT_WIF = 3;
    localparam int WDC_BIT_WRF = 2;
    localparam int WDC_BIT_WRE = 1;
    localparam int WDC_BIT_RST = 0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic WDC_RST_BAUD = 1'b0;
    localparam logic WDC_RST_PFIE = 1'b0;
    localparam logic WDC_RST_WIF = 1'b0;
    localparam logic WDC_RST_WRE = 1'b0;
    localparam logic [9:0] WDC_RESET_DELAY = 10'h0200;
    localparam logic [1:0] WDC_TA_WINDOW = 2'h3;
    localparam logic [25:0] WDC_PERIOD_0 = 26'h000_0000 | 26'h002_0000;
    localparam logic [25:0] WDC_PERIOD_1 = 26'h010_0000;
    localparam logic [25:0] WDC_PERIOD_2 = 26'h080_0000;
    localparam logic [25:0] WDC_PERIOD_3 = 26'h200_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdc_sfr_req_t;

    typedef enum logic [1:0] {
        WDC_TA_IDLE = 2'b00,
        WDC_TA_KEY = 2'b01,
        WDC_TA_OPEN = 2'b10
    } wdc_ta_state_t;

endpackage : wdc_pkg

/* wdc_watchdog_control.sv */
// watchdog control register, timed access, watchdog counter and reset flags
module wdc_watchdog_control #(
    parameter logic [25:0] PERIOD_0 = wdc_pkg::WDC_PERIOD_0,
    parameter logic [25:0] PERIOD_1 = wdc_pkg::WDC_PERIOD_1,
    parameter logic [25:0] PERIOD_2 = wdc_pkg::WDC_PERIOD_2,
    parameter logic [25:0] PERIOD_3 = wdc_pkg::WDC_PERIOD_3,
    parameter logic [9:0] RESET_DELAY = wdc_pkg::WDC_RESET_DELAY
) (
    // clock and resets
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic por_event,
    // special function register access
    input wire wdc_pkg::wdc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // watchdog configuration from other registers
    input wire logic [1:0] wdog_mode_sel,
    input wire logic wdog_int_en,
    // power fail
    input wire logic power_fail_event,
    input wire logic stop_mode,
    input wire logic bandgap_select,
    // outputs to the core
    output logic baud_double,
    output logic wdog_int_req,
    output logic power_fail_int_req,
    output logic wdog_reset_req
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // a zero period wraps the compare, so that mode would expire only once the counter reaches its largest value
    if (PERIOD_0 == 26'h000_0000) begin : g_bad_period_0
        $error("watchdog period 0 must be nonzero");
    end
    if (PERIOD_1 == 26'h000_0000) begin : g_bad_period_1
        $error("watchdog period 1 must be nonzero");
    end
    if (PERIOD_2 == 26'h000_0000) begin : g_bad_period_2
        $error("watchdog period 2 must be nonzero");
    end
    if (PERIOD_3 == 26'h000_0000) begin : g_bad_period_3
        $error("watchdog period 3 must be nonzero");
    end
    // a zero delay wraps the countdown to its largest value
    if (RESET_DELAY == 10'h0000) begin : g_bad_delay
        $error("watchdog reset delay must be nonzero");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic baud_q;
    logic por_flag_q;
    logic pf_int_en_q;
    logic pf_flag_q;
    logic wif_q;
    logic wrf_q;
    logic wre_q;
    logic [25:0] cnt_q;
    logic [9:0] rst_cnt_q;
    logic rst_pend_q;
    logic wdog_rst_q;
    wdc_pkg::wdc_ta_state_t ta_q;
    logic [1:0] ta_win_q;
    logic wr_hit;
    logic ta_ok;
    logic timeout;
    logic restart;
    logic [25:0] period;
    logic [7:0] rd_image;

    assign wr_hit = sfr_req.wr && (sfr_req.addr == wdc_pkg::WDC_ADDR);
    assign sfr_hit = (sfr_req.wr || sfr_req.rd) && (sfr_req.addr == wdc_pkg::WDC_ADDR);
    assign ta_ok = (ta_q == wdc_pkg::WDC_TA_OPEN);
    assign restart = wr_hit && ta_ok && sfr_req.wdata[wdc_pkg::WDC_BIT_RST];

    // ------------------------------------------------------------
    // timed access unlock: key1 then key2 then short window
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ta_q <= wdc_pkg::WDC_TA_IDLE;
            ta_win_q <= 2'h0;
        end else if (clk_en) begin
            case (ta_q)
                wdc_pkg::WDC_TA_IDLE: begin
                    if (sfr_req.wr && sfr_req.wdata == wdc_pkg::WDC_TA_KEY1) begin
                        ta_q <= wdc_pkg::WDC_TA_KEY;
                    end
                end
                wdc_pkg::WDC_TA_KEY: begin
                    if (sfr_req.wr && sfr_req.wdata == wdc_pkg::WDC_TA_KEY2) begin
                        ta_q <= wdc_pkg::WDC_TA_OPEN;
                        ta_win_q <= wdc_pkg::WDC_TA_WINDOW;
                    end else if (sfr_req.wr) begin
                        ta_q <= wdc_pkg::WDC_TA_IDLE;
                    end
                end
                wdc_pkg::WDC_TA_OPEN: begin
                    // one protected write per unlock; window closes on time too
                    if (wr_hit || ta_win_q == 2'h0) begin
                        ta_q <= wdc_pkg::WDC_TA_IDLE;
                    end else begin
                        ta_win_q <= ta_win_q - 2'h1;
                    end
                end
                default: begin
                    ta_q <= wdc_pkg::WDC_TA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // unprotected bits
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            baud_q <= wdc_pkg::WDC_RST_BAUD;
        end else if (clk_en && wr_hit) begin
            baud_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_BAUD];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pf_int_en_q <= wdc_pkg::WDC_RST_PFIE;
        end else if (clk_en && wr_hit) begin
            pf_int_en_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_PFIE];
        end
    end

    // power fail flag: hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (por_event) begin
            pf_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (power_fail_event) begin
                pf_flag_q <= 1'b1;
            end else if (wr_hit) begin
                pf_flag_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_PFF];
            end
        end
    end

    // ------------------------------------------------------------
    // power-on flag and reset enable: only power-on resets them
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (por_event) begin
            por_flag_q <= 1'b1;
        end else if (clk_en && wr_hit && ta_ok) begin
            por_flag_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_POR];
        end
    end

    // warm resets leave the enable alone so a watchdog reset stays armed
    always_ff @(posedge clock) begin
        if (por_event) begin
            wre_q <= wdc_pkg::WDC_RST_WRE;
        end else if (clk_en && wr_hit && ta_ok) begin
            wre_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_WRE];
        end
    end

    // ------------------------------------------------------------
    // watchdog interrupt flag
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wif_q <= wdc_pkg::WDC_RST_WIF;
        end else if (clk_en) begin
            if (timeout) begin
                wif_q <= 1'b1;
            end else if (wr_hit && ta_ok) begin
                wif_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_WIF];
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog reset flag
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (por_event) begin
            wrf_q <= 1'b0;
        end else if (clk_en) begin
            if (wdog_rst_q && wre_q) begin
                wrf_q <= 1'b1;
            end else if (wr_hit) begin
                wrf_q <= sfr_req.wdata[wdc_pkg::WDC_BIT_WRF];
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog counter, independent of reset enable
    // ------------------------------------------------------------
    always_comb begin
        case (wdog_mode_sel)
            2'b00: period = PERIOD_0;
            2'b01: period = PERIOD_1;
            2'b10: period = PERIOD_2;
            2'b11: period = PERIOD_3;
            default: period = PERIOD_0;
        endcase
    end

    assign timeout = (cnt_q >= period - 26'h000_0001) && !restart;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= 26'h000_0000;
        end else if (clk_en) begin
            if (restart || timeout) begin
                cnt_q <= 26'h000_0000;
            end else begin
                cnt_q <= cnt_q + 26'h000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // delayed reset after time-out
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rst_pend_q <= 1'b0;
            rst_cnt_q <= 10'h0000;
            wdog_rst_q <= 1'b0;
        end else if (clk_en) begin
            wdog_rst_q <= 1'b0;
            if (restart || !wre_q) begin
                rst_pend_q <= 1'b0;
            end else if (timeout && !rst_pend_q) begin
                rst_pend_q <= 1'b1;
                rst_cnt_q <= RESET_DELAY - 10'h0001;
            end else if (rst_pend_q) begin
                if (rst_cnt_q == 10'h0000) begin
                    rst_pend_q <= 1'b0;
                    wdog_rst_q <= 1'b1;
                end else begin
                    rst_cnt_q <= rst_cnt_q - 10'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign baud_double = baud_q;
    assign wdog_int_req = wif_q && wdog_int_en;
    // stop mode needs the bandgap reference selected as well
    assign power_fail_int_req = pf_flag_q && pf_int_en_q && (!stop_mode || bandgap_select);
    assign wdog_reset_req = wdog_rst_q;

    always_comb begin
        rd_image = 8'h00;
        rd_image[wdc_pkg::WDC_BIT_BAUD] = baud_q;
        rd_image[wdc_pkg::WDC_BIT_POR] = por_flag_q;
        rd_image[wdc_pkg::WDC_BIT_PFIE] = pf_int_en_q;
        rd_image[wdc_pkg::WDC_BIT_PFF] = pf_flag_q;
        rd_image[wdc_pkg::WDC_BIT_WIF] = wif_q;
        rd_image[wdc_pkg::WDC_BIT_WRF] = wrf_q;
        rd_image[wdc_pkg::WDC_BIT_WRE] = wre_q;
        // restart is a strobe with no storage, so it reads zero
        rd_image[wdc_pkg::WDC_BIT_RST] = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en) begin
            sfr_rdata <= rd_image;
        end
    end

endmodule : wdc_watchdog_control

/* wdc_watchdog_control_monitor.sv */
// checker for the watchdog control register block
module wdc_watchdog_control_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // watched signals
    input wire logic [7:0] sfr_rdata,
    input wire logic wdog_int_en,
    input wire logic stop_mode,
    input wire logic bandgap_select,
    input wire logic baud_double,
    input wire logic wdog_int_req,
    input wire logic power_fail_int_req,
    input wire logic wdog_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ----
    // checks
    // ----
    // read data is the image one edge late, so outputs are compared with $past
    baud_image_a: assert property (clk_en |=> sfr_rdata[7] == $past(baud_double))
        else $error("baud double differs from register bit");
    pf_gate_a: assert property (clk_en |=> $past(power_fail_int_req) ==
        (sfr_rdata[4] && sfr_rdata[5] && (!$past(stop_mode) || $past(bandgap_select))))
        else $error("power fail request not gated by flag and enables");
    wdog_int_gate_a: assert property (wdog_int_req |-> wdog_int_en)
        else $error("watchdog interrupt without enable");
    wdog_int_flag_a: assert property (clk_en |=>
        $past(wdog_int_req) == (sfr_rdata[3] && $past(wdog_int_en)))
        else $error("watchdog interrupt does not follow flag");
    reset_pulse_a: assert property ($rose(wdog_reset_req) |=> !wdog_reset_req)
        else $error("watchdog reset request longer than one cycle");
    reset_flag_a: assert property (wdog_reset_req |-> ##[1:2] sfr_rdata[2])
        else $error("watchdog reset flag not set by reset");
    reset_enable_a: assert property (wdog_reset_req |-> sfr_rdata[1])
        else $error("watchdog reset while reset enable clear");
    restart_read_a: assert property (sfr_rdata[0] == 1'b0)
        else $error("restart bit read as one");
endmodule : wdc_watchdog_control_monitor

/* tb_watchdog_reset_flags_control.sv */
// self-checking bench for the watchdog control register block
module tb_watchdog_reset_flags_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic por_event = 1'b1;
    logic clk_en = 1'b1;
    wdc_pkg::wdc_sfr_req_t sfr_req = '0;
    logic [1:0] wdog_mode_sel = 2'h0;
    logic wdog_int_en = 1'b1;
    logic power_fail_event = 1'b0;
    logic stop_mode = 1'b0;
    logic bandgap_select = 1'b0;
    logic [7:0] sfr_rdata;
    logic sfr_hit, baud_double, wdog_int_req, power_fail_int_req, wdog_reset_req;
    int miscompares = 0;
    int samples_checked = 0;
    int pulses = 0;
    // short periods keep the run small; the reset delay stays at its real count
    wdc_watchdog_control #(.PERIOD_0(26'h000_0040), .PERIOD_1(26'h000_0080),
        .PERIOD_2(26'h000_0100), .PERIOD_3(26'h000_0200)) i_dut (.clock, .rst_n,
        .clk_en, .por_event, .sfr_req, .sfr_rdata, .sfr_hit, .wdog_mode_sel,
        .wdog_int_en, .power_fail_event, .stop_mode, .bandgap_select, .baud_double,
        .wdog_int_req, .power_fail_int_req, .wdog_reset_req);
    always #2 clock = ~clock;
    always @(posedge clock) if (wdog_reset_req === 1'b1) pulses++;
    // ----
    // helpers
    // ----
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock);
        chk(16'(sfr_hit), 16'(a == wdc_pkg::WDC_ADDR));
        sfr_req = '0;
    endtask : req
    task automatic ta_wr(input logic [7:0] d);
        req(1'b1, 8'h00, wdc_pkg::WDC_TA_KEY1);
        req(1'b1, 8'h00, wdc_pkg::WDC_TA_KEY2);
        req(1'b1, wdc_pkg::WDC_ADDR, d);
    endtask : ta_wr
    task automatic rd_chk(input logic [7:0] exp);
        req(1'b0, wdc_pkg::WDC_ADDR, 8'h00);
        chk(16'(sfr_rdata), 16'(exp));
    endtask : rd_chk
    task automatic do_reset(input logic por);
        @(negedge clock);
        rst_n = 1'b0;
        por_event = por;
        cyc(5);
        rst_n = 1'b1;
        por_event = 1'b0;
    endtask : do_reset
    task automatic wait_int(input int lim);
        int n;
        n = 0;
        while (wdog_int_req !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask : wait_int
    // ----
    // scenarios
    // ----
    task automatic t_flags();
        rd_chk(8'h40);
        req(1'b1, wdc_pkg::WDC_ADDR, 8'hff);
        rd_chk(8'hf4);
        chk(16'({baud_double, power_fail_int_req, pulses[0]}), 16'h0006);
        stop_mode = 1'b1;
        cyc(1);
        chk(16'(power_fail_int_req), 16'h0000);
        bandgap_select = 1'b1;
        cyc(1);
        chk(16'(power_fail_int_req), 16'h0001);
        req(1'b1, wdc_pkg::WDC_ADDR, 8'h00);
        power_fail_event = 1'b1;
        cyc(1);
        power_fail_event = 1'b0;
        rd_chk(8'h50);
        ta_wr(8'h02);
        rd_chk(8'h02);
    endtask : t_flags
    task automatic t_timeout();
        int n;
        do_reset(1'b0);
        rd_chk(8'h02);
        wait_int(200);
        n = 0;
        while (wdog_reset_req !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        chk(16'(n), 16'h0200);
        rd_chk(8'h0e);
        do_reset(1'b0);
        rd_chk(8'h06);
        req(1'b1, wdc_pkg::WDC_ADDR, 8'h00);
        rd_chk(8'h02);
    endtask : t_timeout
    task automatic t_restart();
        n_loop: for (int i = 0; i < 4; i++) begin
            cyc(40);
            ta_wr(8'h03);
        end
        chk(16'({wdog_int_req, pulses[7:0]}), 16'h0001);
        req(1'b1, 8'h00, wdc_pkg::WDC_TA_KEY1);
        req(1'b1, 8'h00, 8'h11);
        req(1'b1, 8'h00, wdc_pkg::WDC_TA_KEY2);
        req(1'b1, wdc_pkg::WDC_ADDR, 8'h00);
        rd_chk(8'h02);
        ta_wr(8'h00);
        wait_int(200);
        cyc(600);
        chk(16'({wdog_int_req, pulses[7:0]}), 16'h0101);
        rd_chk(8'h08);
    endtask : t_restart
    task automatic t_modes();
        for (int m = 1; m < 4; m++) begin
            wdog_mode_sel = 2'(m);
            ta_wr(8'h01);
            cyc((64 << m) - 10);
            chk(16'(wdog_int_req), 16'h0000);
            cyc(20);
            chk(16'(wdog_int_req), 16'h0001);
        end
        ta_wr(8'h01);
        req(1'b1, wdc_pkg::WDC_ADDR, 8'h08);
        rd_chk(8'h00);
        ta_wr(8'h08);
        chk(16'(wdog_int_req), 16'h0001);
        wdog_int_en = 1'b0;
        cyc(1);
        chk(16'(wdog_int_req), 16'h0000);
        clk_en = 1'b0;
        req(1'b1, wdc_pkg::WDC_ADDR, 8'h80);
        chk(16'(baud_double), 16'h0000);
        clk_en = 1'b1;
    endtask : t_modes
    // ----
    // run control
    // ----
    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        #60000;
        miscompares++;
        complete_run();
    end
    initial begin
        do_reset(1'b1);
        t_flags();
        t_timeout();
        t_restart();
        t_modes();
        complete_run();
    end
endmodule : tb_watchdog_reset_flags_control
bind wdc_watchdog_control wdc_watchdog_control_monitor i_mon (.clock, .rst_n, .clk_en,
    .sfr_rdata, .wdog_int_en, .stop_mode, .bandgap_select, .baud_double, .wdog_int_req,
    .power_fail_int_req, .wdog_reset_req);
